// >>> rtl/cdt_pkg.sv
// Constants and types for the countdown timer and alarm mode block.
// Assumes a 40 MHz ref_clk and a 256 Hz tick from the calendar timebase.
//
// How it works
// RQ1: While the enable bit is set, the countdown value decrements.
// RQ2: Clearing enable stops counting at once and keeps the current value.
// RQ3: With repeat set, a zero value reloads from the initial value register.
// RQ4: With repeat clear, the value stays at zero with no reload.
// RQ5: Software starts a countdown by raising repeat, then may clear it.
// RQ6: The read-only value drops by one per selected period, if enabled, nonzero.
// RQ7: Rate field: 00 256 Hz, 01 1 Hz, 10 once a minute, 11 once an hour.
// RQ8: Alarm mode selects the compared fields; a full match raises the alarm.
// RQ9: Alarm mode zero disables matching and is the reset default.
// RQ10: Alarm modes 9 to 15 are invalid and also disable the alarm.
// RQ11: Modes 1 to 4: yearly, monthly, weekly (weekday), daily field sets.
// RQ12: Modes 5 to 8: hourly, each minute, each second, ten per second.
// RQ13: Reaching zero sets a readable, clearable countdown flag once per expiry.
package cdt_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] CDT_OFS_CTRL = 8'h18;
   localparam logic [7:0] CDT_OFS_VALUE = 8'h19;
   localparam logic [7:0] CDT_OFS_INIT = 8'h1a;
   localparam logic [7:0] CDT_OFS_FLAGS = 8'h1c;

   // -------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------
   localparam int CDT_BIT_ENABLE = 7;
   localparam int CDT_BIT_REPEAT = 6;
   localparam int CDT_MODE_HI = 5;
   localparam int CDT_MODE_LO = 2;
   localparam int CDT_RATE_HI = 1;
   localparam int CDT_RATE_LO = 0;
   localparam int CDT_BIT_CD_FLAG = 0;
   localparam int CDT_BIT_AL_FLAG = 1;
   localparam logic [7:0] CDT_CTRL_RST = 8'h00;
   localparam logic [7:0] CDT_VALUE_RST = 8'h00;
   localparam logic [7:0] CDT_INIT_RST = 8'h00;

   // -------------------------------------------------------------
   // Timebase counts, minus one: 256 Hz ticks per second, seconds per minute, minutes per hour
   // -------------------------------------------------------------
   localparam logic [7:0] CDT_TICKS_PER_SEC_M1 = 8'hff;
   localparam logic [5:0] CDT_SEC_PER_MIN_M1 = 6'h3b;
   localparam logic [5:0] CDT_MIN_PER_HOUR_M1 = 6'h3b;

   typedef enum logic [1:0]
   {
      CDT_RATE_256HZ = 2'b00,
      CDT_RATE_1HZ = 2'b01,
      CDT_RATE_MIN = 2'b10,
      CDT_RATE_HOUR = 2'b11
   } cdt_rate_e;

   // Match enables, msb first: month date weekday hour min sec tenth hundredth
   typedef logic [7:0] cdt_mask_t;

endpackage

// >>> rtl/cdt_rate_div.sv
// Rate divider: turns the 256 Hz tick into the selected countdown tick.
// Assumes tick_256hz is a one-cycle pulse from logic on ref_clk.
`timescale 1ns/1ps
module cdt_rate_div
   import cdt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tick_256hz,
   input wire logic [1:0] rate_sel,
   output logic rate_tick
);

   typedef struct packed
   {
      logic [7:0] div;
      logic [5:0] sec;
      logic [5:0] min;
      logic tick;
   } cdt_div_s;

   cdt_div_s st_reg;
   cdt_div_s st_next;

   always_comb
   begin
      logic t_sec;
      logic t_min;
      logic t_hour;
      st_next = st_reg;
      t_sec = tick_256hz && (st_reg.div == CDT_TICKS_PER_SEC_M1);
      t_min = t_sec && (st_reg.sec == CDT_SEC_PER_MIN_M1);
      t_hour = t_min && (st_reg.min == CDT_MIN_PER_HOUR_M1);
      if (tick_256hz)
      begin
         st_next.div = st_reg.div + 8'h01;
      end
      if (t_sec)
      begin
         st_next.sec = t_min ? 6'h00 : st_reg.sec + 6'h01;
      end
      if (t_min)
      begin
         st_next.min = t_hour ? 6'h00 : st_reg.min + 6'h01;
      end
      // Free-running chain, so the first tick after a rate change is early
      unique case (cdt_rate_e'(rate_sel)) // [RQ7]
         CDT_RATE_256HZ: st_next.tick = tick_256hz;
         CDT_RATE_1HZ: st_next.tick = t_sec;
         CDT_RATE_MIN: st_next.tick = t_min;
         CDT_RATE_HOUR: st_next.tick = t_hour;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign rate_tick = st_reg.tick;

endmodule

// >>> rtl/cdt_timer_alarm.sv
// Countdown timer and alarm mode control of the real-time clock.
// Assumes the serial port front end supplies one-cycle register strobes on
// ref_clk, and calendar and alarm fields are stable values on ref_clk.
`timescale 1ns/1ps
module cdt_timer_alarm
   import cdt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic tick_256hz,
   input wire logic [7:0] time_month,
   input wire logic [7:0] time_date,
   input wire logic [7:0] time_weekday,
   input wire logic [7:0] time_hours,
   input wire logic [7:0] time_minutes,
   input wire logic [7:0] time_seconds,
   input wire logic [7:0] time_hundredths,
   input wire logic [7:0] alarm_month,
   input wire logic [7:0] alarm_date,
   input wire logic [7:0] alarm_weekday,
   input wire logic [7:0] alarm_hours,
   input wire logic [7:0] alarm_minutes,
   input wire logic [7:0] alarm_seconds,
   input wire logic [7:0] alarm_hundredths,
   output logic countdown_irq,
   output logic alarm_irq
);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic cdt_mask_t mode_mask(input logic [3:0] mode);
      unique case (mode) // [RQ8]
         4'h1: mode_mask = 8'hdf; // [RQ11]
         4'h2: mode_mask = 8'h5f; // [RQ11]
         4'h3: mode_mask = 8'h3f; // [RQ11]
         4'h4: mode_mask = 8'h1f; // [RQ11]
         4'h5: mode_mask = 8'h0f; // [RQ12]
         4'h6: mode_mask = 8'h07; // [RQ12]
         4'h7: mode_mask = 8'h03; // [RQ12]
         4'h8: mode_mask = 8'h01; // [RQ12]
         default: mode_mask = 8'h00; // [RQ9] [RQ10]
      endcase
   endfunction

   function automatic logic field_eq(input logic [7:0] a, input logic [7:0] b);
      field_eq = (a == b);
   endfunction

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] ctrl;
      logic [7:0] value;
      logic [7:0] init;
      logic [7:0] rdata;
      logic cd_flag;
      logic al_flag;
      logic match_d;
   } cdt_top_s;

   cdt_top_s st_reg;
   cdt_top_s st_next;
   logic rate_tick;
   logic [3:0] mode;
   logic [1:0] rate_sel;
   cdt_mask_t eq_vec;

   assign mode = st_reg.ctrl[CDT_MODE_HI:CDT_MODE_LO];
   assign rate_sel = st_reg.ctrl[CDT_RATE_HI:CDT_RATE_LO];

   // -------------------------------------------------------------
   // Rate divider
   // -------------------------------------------------------------
   cdt_rate_div u_div
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick_256hz(tick_256hz),
      .rate_sel(rate_sel),
      .rate_tick(rate_tick)
   );

   // -------------------------------------------------------------
   // Alarm field compare
   // -------------------------------------------------------------
   // Tenths and hundredths share one byte, so they compare as nibbles
   assign eq_vec =
   {
      field_eq(time_month, alarm_month),
      field_eq(time_date, alarm_date),
      field_eq(time_weekday, alarm_weekday),
      field_eq(time_hours, alarm_hours),
      field_eq(time_minutes, alarm_minutes),
      field_eq(time_seconds, alarm_seconds),
      field_eq({4'h0, time_hundredths[7:4]}, {4'h0, alarm_hundredths[7:4]}),
      field_eq({4'h0, time_hundredths[3:0]}, {4'h0, alarm_hundredths[3:0]})
   };

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      cdt_mask_t msk;
      logic match;
      logic cd_set;
      logic al_set;
      st_next = st_reg;

      // -------------------------------------------------------------
      // Alarm match
      // -------------------------------------------------------------
      msk = mode_mask(mode);
      // An all-zero mask means disabled, never a trivial match
      match = (msk != 8'h00) && ((eq_vec & msk) == msk); // [RQ8] [RQ9] [RQ10]
      st_next.match_d = match;
      al_set = match && !st_reg.match_d;
      cd_set = 1'b0;

      // -------------------------------------------------------------
      // Countdown
      // -------------------------------------------------------------
      // Reload ignores enable, so a stopped timer at zero still reloads
      if (st_reg.value == 8'h00)
      begin
         if (st_reg.ctrl[CDT_BIT_REPEAT])
         begin
            st_next.value = st_reg.init; // [RQ3] [RQ5]
         end
         // Repeat clear: held at zero [RQ4]
      end
      else if (st_reg.ctrl[CDT_BIT_ENABLE] && rate_tick) // [RQ1] [RQ2]
      begin
         st_next.value = st_reg.value - 8'h01; // [RQ6]
         cd_set = (st_reg.value == 8'h01); // [RQ13]
      end

      // -------------------------------------------------------------
      // Register write
      // -------------------------------------------------------------
      // Value register is read-only; a write to it falls to the default
      if (reg_wr)
      begin
         unique case (reg_addr)
            CDT_OFS_CTRL: st_next.ctrl = reg_wdata;
            CDT_OFS_INIT: st_next.init = reg_wdata;
            CDT_OFS_FLAGS:
            begin
               if (reg_wdata[CDT_BIT_CD_FLAG])
               begin
                  st_next.cd_flag = 1'b0;
               end
               if (reg_wdata[CDT_BIT_AL_FLAG])
               begin
                  st_next.al_flag = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // -------------------------------------------------------------
      // Flag set
      // -------------------------------------------------------------
      // Hardware set beats a same-cycle software clear
      if (cd_set)
      begin
         st_next.cd_flag = 1'b1; // [RQ13]
      end
      if (al_set)
      begin
         st_next.al_flag = 1'b1; // [RQ8]
      end

      // -------------------------------------------------------------
      // Register read
      // -------------------------------------------------------------
      // Read data is registered and holds until the next read strobe
      if (reg_rd)
      begin
         unique case (reg_addr)
            CDT_OFS_CTRL: st_next.rdata = st_reg.ctrl;
            CDT_OFS_VALUE: st_next.rdata = st_reg.value; // [RQ2]
            CDT_OFS_INIT: st_next.rdata = st_reg.init;
            CDT_OFS_FLAGS: st_next.rdata = {6'h00, st_reg.al_flag, st_reg.cd_flag};
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg.ctrl <= CDT_CTRL_RST; // [RQ9]
         st_reg.value <= CDT_VALUE_RST;
         st_reg.init <= CDT_INIT_RST;
         st_reg.rdata <= 8'h00;
         st_reg.cd_flag <= 1'b0;
         st_reg.al_flag <= 1'b0;
         st_reg.match_d <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign reg_rdata = st_reg.rdata;
   assign countdown_irq = st_reg.cd_flag;
   assign alarm_irq = st_reg.al_flag;

endmodule

// >>> tb/cdt_timer_alarm_assertions.sv
// Port checker for the countdown timer and alarm block.
// Bound onto cdt_timer_alarm; sees only its ports.
`timescale 1ns/1ps
module cdt_timer_alarm_chk
   import cdt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic tick_256hz,
   input wire logic [7:0] time_hundredths,
   input wire logic [7:0] alarm_hundredths,
   input wire logic countdown_irq,
   input wire logic alarm_irq
);
   logic [7:0] ctl_reg;
   logic [7:0] ini_reg;
   logic fw;
   assign fw = reg_wr && reg_addr == CDT_OFS_FLAGS;
   // Shadows of the writable registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_reg <= 8'h00;
         ini_reg <= 8'h00;
      end
      else if (reg_wr)
      begin
         if (reg_addr == CDT_OFS_CTRL)
            ctl_reg <= reg_wdata;
         if (reg_addr == CDT_OFS_INIT)
            ini_reg <= reg_wdata;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
   ctrl_read_a: assert property (reg_rd && reg_addr == CDT_OFS_CTRL
      |=> reg_rdata == $past(ctl_reg)) else $error("ctrl readback");
   init_read_a: assert property (reg_rd && reg_addr == CDT_OFS_INIT
      |=> reg_rdata == $past(ini_reg)) else $error("init readback");
   flag_read_a: assert property (reg_rd && reg_addr == CDT_OFS_FLAGS
      |=> reg_rdata[1:0] == $past({alarm_irq, countdown_irq})) else $error("flag read");
   cd_hold_a: assert property (countdown_irq && !(fw && reg_wdata[0])
      |=> countdown_irq) else $error("countdown flag lost");
   cd_clear_a: assert property (countdown_irq && fw && reg_wdata[0] && !$past(tick_256hz)
      && !$past(tick_256hz, 2) && !$past(tick_256hz, 3) |=> !countdown_irq)
      else $error("countdown flag kept");
   cd_rise_a: assert property ($rose(countdown_irq)
      |-> $past(tick_256hz, 2) || $past(tick_256hz, 3)) else $error("flag without tick");
   al_hold_a: assert property (alarm_irq && !(fw && reg_wdata[1]) |=> alarm_irq)
      else $error("alarm flag lost");
   al_mode_a: assert property ($rose(alarm_irq) |-> $past(ctl_reg[5:2]) inside {[1:8]})
      else $error("alarm in off mode");
   al_match_a: assert property ($rose(alarm_irq)
      |-> $past(time_hundredths[3:0] == alarm_hundredths[3:0])) else $error("alarm no match");
   cover property ($rose(countdown_irq));
   cover property ($rose(alarm_irq));
   cover property (reg_rd && reg_addr == CDT_OFS_VALUE);
endmodule

// >>> tb/tb_cdt_timer_alarm.sv
// Self-checking bench for the countdown timer and alarm block.
// Drives strobes, ticks and calendar fields itself on falling edges.
`timescale 1ns/1ps
module tb_cdt_timer_alarm;
   import cdt_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic tick_256hz = 1'b0;
   logic [7:0] reg_rdata;
   logic countdown_irq;
   logic alarm_irq;
   logic [7:0] tm [7] = '{default: 8'h00};
   logic [7:0] al [7] = '{default: 8'h00};
   logic [31:0] seed = 32'h90427a64;
   logic [7:0] n, d, r8;
   int n_fail = 0;
   int samples_checked = 0;
   always #12.5 ref_clk = ~ref_clk;
   cdt_timer_alarm i_cdt_timer_alarm (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .tick_256hz, .time_month(tm[0]), .time_date(tm[1]),
      .time_weekday(tm[2]), .time_hours(tm[3]), .time_minutes(tm[4]), .time_seconds(tm[5]),
      .time_hundredths(tm[6]), .alarm_month(al[0]), .alarm_date(al[1]),
      .alarm_weekday(al[2]), .alarm_hours(al[3]), .alarm_minutes(al[4]),
      .alarm_seconds(al[5]), .alarm_hundredths(al[6]), .countdown_irq, .alarm_irq);
   // ----------------
   // Helpers
   // ----------------
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   // Compared fields, msb first: month date weekday hour min sec tenth hundredth
   function automatic logic [7:0] mk(input int m);
      case (m)
         1: return 8'hdf;
         2: return 8'h5f;
         3: return 8'h3f;
         4: return 8'h1f;
         5: return 8'h0f;
         6: return 8'h07;
         7: return 8'h03;
         8: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   // Two cycles per tick keeps the hour-free rates inside the run budget
   task automatic ticks(input int c);
      repeat (c)
      begin
         @(negedge ref_clk);
         tick_256hz = 1'b1;
         @(negedge ref_clk);
         tick_256hz = 1'b0;
      end
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic setal(input logic [7:0] v);
      for (int i = 0; i < 6; i++)
         al[i] = tm[i] ^ {7'h00, v[7 - i]};
      al[6] = tm[6] ^ {3'h0, v[1], 3'h0, v[0]};
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      rc(CDT_OFS_CTRL, CDT_CTRL_RST);
      rc(CDT_OFS_FLAGS, 8'h00);
      rc(8'h1f, 8'h00);
      n = 8'h10 | (rnd() & 8'h3f);
      wr(CDT_OFS_INIT, n);
      wr(CDT_OFS_CTRL, 8'hc0);
      rc(CDT_OFS_VALUE, n);
      wr(CDT_OFS_CTRL, 8'h80);
      wr(CDT_OFS_VALUE, ~n);
      ticks(3);
      rc(CDT_OFS_VALUE, n - 8'd3);
      wr(CDT_OFS_CTRL, 8'h00);
      ticks(4);
      rc(CDT_OFS_VALUE, n - 8'd3);
      wr(CDT_OFS_CTRL, 8'h80);
      ticks(int'(n) - 3);
      chk({7'h00, countdown_irq}, 8'h01);
      ticks(2);
      rc(CDT_OFS_VALUE, 8'h00);
      wr(CDT_OFS_FLAGS, 8'h01);
      rc(CDT_OFS_FLAGS, 8'h00);
      wr(CDT_OFS_CTRL, 8'hc0);
      rc(CDT_OFS_VALUE, n);
      for (int r = 0; r < 3; r++)
      begin
         wr(CDT_OFS_CTRL, 8'h80 | 8'(r));
         ticks(r == 0 ? 1 : r == 1 ? 256 : 15360);
         rc(CDT_OFS_VALUE, n - 8'(r) - 8'd1);
      end
      wr(CDT_OFS_CTRL, 8'h03);
      rc(CDT_OFS_CTRL, 8'h03);
      for (int m = 0; m < 16; m++)
      begin
         r8 = rnd();
         d = ~mk(m) | (r8[7] ? (8'h01 << r8[2:0]) : 8'h00);
         foreach (tm[i]) tm[i] = rnd();
         setal(d | 8'h01);
         wr(CDT_OFS_CTRL, {2'b00, 4'(m), 2'b00});
         wr(CDT_OFS_FLAGS, 8'h02);
         setal(d);
         repeat (3) @(negedge ref_clk);
         chk({7'h00, alarm_irq}, {7'h00, m inside {[1:8]} && (d & mk(m)) == 0});
      end
      tally_and_finish();
   end
endmodule
bind cdt_timer_alarm cdt_timer_alarm_chk i_cdt_timer_alarm_chk (.ref_clk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tick_256hz, .time_hundredths,
   .alarm_hundredths, .countdown_irq, .alarm_irq);
